/* File: rtl/srw_regs.svh */
// Constants for the supervisor reset and watchdog block.
// Assumes a 25 MHz system clock; included by its bare name.
`ifndef SRW_REGS_SVH
`define SRW_REGS_SVH

// Clock rate in kHz, used to turn milliseconds into cycles
`define SRW_CLK_KHZ 25000
// Hold-time select encodings and the power-up choice
`define SRW_HOLD_SEL_RST 2'h1
`define SRW_HOLD_MS_00 50
`define SRW_HOLD_MS_01 200
`define SRW_HOLD_MS_10 400
`define SRW_HOLD_MS_11 800
// Watchdog period select encodings and the power-up choice
`define SRW_WDOG_SEL_RST 2'h3
`define SRW_WDOG_MS_00 1400
`define SRW_WDOG_MS_01 200
`define SRW_WDOG_MS_10 25
`define SRW_WDOG_OFF 2'h3
// Control byte field positions
`define SRW_CTL_HOLD_HI 7
`define SRW_CTL_WD_HI 6
`define SRW_CTL_WD_LO 5
`define SRW_CTL_HOLD_LO 0
// Counter width for the longest interval
`define SRW_CNT_W 26

`endif

/* File: rtl/srw_pkg.sv */
// Types shared by the supervisor reset and watchdog block.
// Assumes nothing beyond a SystemVerilog compiler.
package srw_pkg;

  // Digital comparator flags, high means supply above its threshold
  typedef struct packed {
    logic main_ok;
    logic aux1_ok;
    logic aux2_ok;
  } srw_supply_t;

  // Nonvolatile selects
  typedef struct packed {
    logic [1:0] hold_sel;
    logic [1:0] wdog_sel;
  } srw_cfg_t;

  // Two-wire bus watcher states
  typedef enum logic [2:0] {
    SRW_BUS_IDLE = 3'h1,
    SRW_BUS_START = 3'h2,
    SRW_BUS_CLKD = 3'h4
  } srw_bus_st_t;

endpackage : srw_pkg

/* File: rtl/srw_bus_watch.sv */
// Two-wire bus watcher: pulses when a start, a clock toggle and a stop
// have been seen in order. Assumes bus pins already synchronous.
module srw_bus_watch
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic restart_pulse
);

  ////////////////////////////////////////////////////////////////////////
  // Edge detection on the bus lines
  logic scl_d_ff; // Delayed clock line
  logic sda_d_ff; // Delayed data line
  srw_pkg::srw_bus_st_t st_ff; // Watcher state
  srw_pkg::srw_bus_st_t nxt_st; // Next watcher state
  logic start_seen; // Data falls while clock high
  logic stop_seen; // Data rises while clock high
  logic scl_fall; // Clock high to low

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      scl_d_ff <= 1'h1;
      sda_d_ff <= 1'h1;
    end
    else
    begin
      scl_d_ff <= scl_in;
      sda_d_ff <= sda_in;
    end
  end

  assign start_seen = scl_in && scl_d_ff && sda_d_ff && !sda_in;
  assign stop_seen = scl_in && scl_d_ff && !sda_d_ff && sda_in;
  assign scl_fall = scl_d_ff && !scl_in;

  ////////////////////////////////////////////////////////////////////////
  // Sequence tracking: start, clock low, clock high, stop
  always_comb
  begin
    nxt_st = st_ff;
    case (st_ff)
      srw_pkg::SRW_BUS_IDLE:
        if (start_seen)
          nxt_st = srw_pkg::SRW_BUS_START; // [R15]
      srw_pkg::SRW_BUS_START:
        if (scl_fall)
          nxt_st = srw_pkg::SRW_BUS_CLKD; // [R15]
        else if (stop_seen)
          nxt_st = srw_pkg::SRW_BUS_IDLE; // No toggle, no restart
      srw_pkg::SRW_BUS_CLKD:
        if (stop_seen)
          nxt_st = srw_pkg::SRW_BUS_IDLE; // [R12]
        else if (start_seen)
          nxt_st = srw_pkg::SRW_BUS_START; // Repeated start
      default:
        nxt_st = srw_pkg::SRW_BUS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      st_ff <= srw_pkg::SRW_BUS_IDLE;
    else
      st_ff <= nxt_st;
  end

  // One pulse at the stop that closes a full sequence
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      restart_pulse <= 1'h0;
    else
      restart_pulse <= (st_ff == srw_pkg::SRW_BUS_CLKD) && stop_seen; // [R12]
  end

endmodule : srw_bus_watch

/* File: rtl/srw_supervisor.sv */
// Supervisor top: reset hold, supply fail outputs, watchdog and the
// nonvolatile select byte. Assumes comparator flags and bus pins are
// synchronous to sys_clk; nonvolatile storage sits outside.
//
// Functional notes
// [R1] Write-protect high blocks all writes
// [R2] Watchdog fault is active-low open-drain
// [R3] Aux2 fail low below threshold, no hold
// [R4] Aux2 fail follows comparator, no timing
// [R5] System reset asserted at power-up
// [R6] Release after main supply good hold time
// [R7] Manual reset holds, then extends hold time
// [R8] Main supply low asserts reset, restarts hold
// [R9] Aux1 fail stays until aux1 recovers
// [R10] Aux2 fail stays until aux2 recovers
// [R11] Early low output, no hold delay
// [R12] Any full bus sequence restarts watchdog
// [R13] Host sends start, clock low, high, stop
// [R14] Two nonvolatile bits choose watchdog period
// [R15] Restart needs data fall, toggle, stop
// [R16] Hold select: 50/200/400/800 ms
// [R17] Watchdog: 1.4 s/200 ms/25 ms/off
// [R18] Reset output in two polarity variants
// [R19] Fault stays until next valid restart
// [R20] One time base; counters cleared in reset
//
// Implementation choices: the address map and the strobed register port.
`include "srw_regs.svh"

module srw_supervisor
#(
  parameter bit RST_ACTIVE_HIGH = 1'b0, // Push-pull active-high variant
  parameter int CLK_KHZ = `SRW_CLK_KHZ, // Time-base rate in kHz
  parameter int HOLD_00 = `SRW_HOLD_MS_00 * `SRW_CLK_KHZ,
  parameter int HOLD_01 = `SRW_HOLD_MS_01 * `SRW_CLK_KHZ,
  parameter int HOLD_10 = `SRW_HOLD_MS_10 * `SRW_CLK_KHZ,
  parameter int HOLD_11 = `SRW_HOLD_MS_11 * `SRW_CLK_KHZ,
  parameter int WDOG_00 = `SRW_WDOG_MS_00 * `SRW_CLK_KHZ,
  parameter int WDOG_01 = `SRW_WDOG_MS_01 * `SRW_CLK_KHZ,
  parameter int WDOG_10 = `SRW_WDOG_MS_10 * `SRW_CLK_KHZ
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire srw_pkg::srw_supply_t supply_ok,
  input wire logic manual_reset_req_n,
  input wire logic write_protect,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic sys_reset_out,
  output logic sys_reset_oe,
  output logic watchdog_fault_n,
  output logic watchdog_fault_oe,
  output logic aux1_undervolt_n,
  output logic aux1_undervolt_oe,
  output logic aux2_undervolt_n,
  output logic aux2_undervolt_oe,
  output logic early_supply_low_n
);

  ////////////////////////////////////////////////////////////////////////
  // Local constants
  localparam logic [7:0] ADDR_CTL = 8'h00; // Select byte
  localparam logic [7:0] ADDR_STAT = 8'h01; // Live status byte
  localparam int CW = `SRW_CNT_W; // Counter width

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  srw_pkg::srw_cfg_t cfg_ff; // Hold and watchdog selects
  logic [CW-1:0] hold_cnt_ff; // Reset hold counter
  logic [CW-1:0] nxt_hold_cnt; // Next hold count
  logic [CW-1:0] hold_lim; // Selected hold length
  logic [CW-1:0] wd_cnt_ff; // Watchdog counter
  logic [CW-1:0] wd_lim; // Selected watchdog length
  logic reset_req; // Any cause to hold reset
  logic in_reset_ff; // System reset active
  logic wd_fault_ff; // Watchdog expired
  logic wd_restart; // Valid bus restart pulse
  logic wd_off; // Watchdog disabled

  ////////////////////////////////////////////////////////////////////////
  // Bus activity watcher
  srw_bus_watch u_bus_watch
  (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .restart_pulse(wd_restart)
  );

  ////////////////////////////////////////////////////////////////////////
  // Select byte write, blocked by write protect
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      cfg_ff.hold_sel <= `SRW_HOLD_SEL_RST; // [R16]
      cfg_ff.wdog_sel <= `SRW_WDOG_SEL_RST; // [R17]
    end
    else if (reg_wr && !write_protect && reg_addr == ADDR_CTL) // [R1]
    begin
      // Hold and period selects take the control byte layout
      cfg_ff.hold_sel <= {reg_wdata[`SRW_CTL_HOLD_HI],
                          reg_wdata[`SRW_CTL_HOLD_LO]};
      cfg_ff.wdog_sel <= {reg_wdata[`SRW_CTL_WD_HI],
                          reg_wdata[`SRW_CTL_WD_LO]}; // [R14]
    end
  end

  // Read data one cycle after the strobe, zero when idle or unmapped
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd && reg_addr == ADDR_CTL)
    begin
      reg_rdata <= 8'h00;
      reg_rdata[`SRW_CTL_HOLD_HI] <= cfg_ff.hold_sel[1];
      reg_rdata[`SRW_CTL_HOLD_LO] <= cfg_ff.hold_sel[0];
      reg_rdata[`SRW_CTL_WD_HI] <= cfg_ff.wdog_sel[1];
      reg_rdata[`SRW_CTL_WD_LO] <= cfg_ff.wdog_sel[0];
    end
    else if (reg_rd && reg_addr == ADDR_STAT)
      // Live state: reset, fault, and the three comparator flags
      reg_rdata <= {3'h0, in_reset_ff, wd_fault_ff, supply_ok};
    else
      reg_rdata <= 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////
  // Interval lookups in cycles of the one time base
  always_comb
  begin
    case (cfg_ff.hold_sel) // [R16]
      2'h0: hold_lim = CW'(HOLD_00);
      2'h1: hold_lim = CW'(HOLD_01);
      2'h2: hold_lim = CW'(HOLD_10);
      default: hold_lim = CW'(HOLD_11);
    endcase
  end

  always_comb
  begin
    case (cfg_ff.wdog_sel) // [R17]
      2'h0: wd_lim = CW'(WDOG_00);
      2'h1: wd_lim = CW'(WDOG_01);
      2'h2: wd_lim = CW'(WDOG_10);
      default: wd_lim = CW'(WDOG_00);
    endcase
  end

  assign wd_off = (cfg_ff.wdog_sel == `SRW_WDOG_OFF); // [R17]

  ////////////////////////////////////////////////////////////////////////
  // Reset hold: any cause clears the count, release after full hold
  assign reset_req = !supply_ok.main_ok || !manual_reset_req_n; // [R7] [R8]

  always_comb
  begin
    if (reset_req)
      nxt_hold_cnt = '0; // [R6] [R7] [R8]
    else if (hold_cnt_ff < hold_lim)
      nxt_hold_cnt = hold_cnt_ff + CW'(1);
    else
      nxt_hold_cnt = hold_cnt_ff;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      hold_cnt_ff <= '0; // [R20]
    else
      hold_cnt_ff <= nxt_hold_cnt;
  end

  // Reset state, active from power-up until the hold completes
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      in_reset_ff <= 1'h1; // [R5]
    else if (reset_req)
      in_reset_ff <= 1'h1; // [R7] [R8]
    else if (hold_cnt_ff >= hold_lim)
      in_reset_ff <= 1'h0; // [R6]
  end

  // Pin drive for the selected polarity variant
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      sys_reset_out <= RST_ACTIVE_HIGH; // [R5] [R18]
      sys_reset_oe <= 1'h1;
    end
    else if (RST_ACTIVE_HIGH)
    begin
      sys_reset_out <= nxt_hold_cnt < hold_lim || reset_req; // [R18]
      sys_reset_oe <= 1'h1; // Push-pull always drives
    end
    else
    begin
      // Open drain: low while driven, released level otherwise
      sys_reset_out <= !(nxt_hold_cnt < hold_lim || reset_req); // [R18]
      sys_reset_oe <= nxt_hold_cnt < hold_lim || reset_req; // [R18]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Watchdog counter, reloaded on each valid restart
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      wd_cnt_ff <= '0; // [R20]
    else if (wd_restart || wd_off)
      wd_cnt_ff <= '0; // [R12] [R19]
    else if (wd_cnt_ff < wd_lim)
      wd_cnt_ff <= wd_cnt_ff + CW'(1);
  end

  // Sticky fault until the next restart; restart wins over expiry
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      wd_fault_ff <= 1'h0;
    else if (wd_restart || wd_off)
      wd_fault_ff <= 1'h0; // [R19]
    else if (wd_cnt_ff + CW'(1) >= wd_lim)
      wd_fault_ff <= 1'h1; // [R19]
  end

  // Open-drain fault pin, pulled low while faulted
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      watchdog_fault_n <= 1'h1;
      watchdog_fault_oe <= 1'h0;
    end
    else
    begin
      // Low exactly while the pin is driven
      watchdog_fault_n <= wd_restart || wd_off ||
        !(wd_fault_ff || wd_cnt_ff + CW'(1) >= wd_lim); // [R2]
      watchdog_fault_oe <= !(wd_restart || wd_off) &&
        (wd_fault_ff || wd_cnt_ff + CW'(1) >= wd_lim); // [R2]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Supply fail outputs, one flop behind the comparator, no hold
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      aux1_undervolt_n <= 1'h1;
      aux1_undervolt_oe <= 1'h0;
      aux2_undervolt_n <= 1'h1;
      aux2_undervolt_oe <= 1'h0;
      early_supply_low_n <= 1'h0;
    end
    else
    begin
      // Pin level low only while driven
      aux1_undervolt_n <= supply_ok.aux1_ok;
      aux1_undervolt_oe <= !supply_ok.aux1_ok; // [R9]
      aux2_undervolt_n <= supply_ok.aux2_ok;
      aux2_undervolt_oe <= !supply_ok.aux2_ok; // [R3] [R4] [R10]
      early_supply_low_n <= supply_ok.main_ok; // [R11]
    end
  end

endmodule : srw_supervisor

/* File: testbench/srw_supervisor_sva.sv */
// Checker for the supervisor top: timing of its output pins.
// Assumes it is bound to srw_supervisor and sees only its ports.
module srw_supervisor_chk
#(
  parameter int HOLD_00 = 20 // Shortest hold, cycles
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire srw_pkg::srw_supply_t supply_ok,
  input wire logic manual_reset_req_n,
  input wire logic sys_reset_out,
  input wire logic sys_reset_oe,
  input wire logic watchdog_fault_n,
  input wire logic watchdog_fault_oe,
  input wire logic aux1_undervolt_oe,
  input wire logic aux2_undervolt_n,
  input wire logic aux2_undervolt_oe,
  input wire logic early_supply_low_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [31:0] quiet_ff; // Cycles with no reset cause
  ////////////////////////////////////////
  // Quiet counter, cleared by any reset cause
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || !supply_ok.main_ok || !manual_reset_req_n)
      quiet_ff <= 32'h0;
    else if (quiet_ff != 32'hFFFF)
      quiet_ff <= quiet_ff + 32'h1;
  end
  property p_pwr; $rose(rst_n) |-> sys_reset_oe && !sys_reset_out;
  endproperty
  a_pwr: assert property (p_pwr) else $error("no reset at start");
  property p_main; !supply_ok.main_ok |=> sys_reset_oe; endproperty
  a_main: assert property (p_main) else $error("low main no reset");
  property p_man; !manual_reset_req_n |=> sys_reset_oe; endproperty
  a_man: assert property (p_man) else $error("manual no reset");
  property p_rel; $fell(sys_reset_oe) |-> quiet_ff >= HOLD_00;
  endproperty
  a_rel: assert property (p_rel) else $error("early release");
  property p_a2; 1'b1 |=> aux2_undervolt_oe == !$past(supply_ok.aux2_ok);
  endproperty
  a_a2: assert property (p_a2) else $error("aux2 pin wrong");
  property p_a1; !supply_ok.aux1_ok [*2] |=> aux1_undervolt_oe;
  endproperty
  a_a1: assert property (p_a1) else $error("aux1 pin wrong");
  property p_early;
    $past(rst_n) |-> early_supply_low_n == $past(supply_ok.main_ok);
  endproperty
  a_early: assert property (p_early) else $error("early pin");
  property p_od;
    (watchdog_fault_n == !watchdog_fault_oe) &&
      (aux2_undervolt_n == !aux2_undervolt_oe);
  endproperty
  a_od: assert property (p_od) else $error("drain pin high");
endmodule : srw_supervisor_chk

bind srw_supervisor srw_supervisor_chk #(.HOLD_00(HOLD_00)) u_chk
(
  .sys_clk, .rst_n, .supply_ok, .manual_reset_req_n, .sys_reset_out,
  .sys_reset_oe, .watchdog_fault_n, .watchdog_fault_oe, .aux1_undervolt_oe,
  .aux2_undervolt_n,
  .aux2_undervolt_oe, .early_supply_low_n
);

/* File: testbench/srw_host_model.sv */
// Host model: two-wire master making start and stop, with a clock toggle only when host_full.
// Assumes pull-ups on both lines, so the idle level is high.
module srw_host_model
(
  input wire logic sys_clk,
  input wire logic host_go,
  input wire logic host_full,
  input wire logic host_slow,
  output logic scl,
  output logic sda,
  output logic host_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  // One bus level, held two or six cycles
  task step(input logic c, input logic dv);
    scl <= c;
    sda <= dv;
    repeat (host_slow ? 6 : 2) @(posedge sys_clk);
  endtask : step
  // Start, optional clock toggle, stop
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
    host_busy = 1'b0;
    forever
    begin
      @(posedge sys_clk);
      if (host_go)
      begin
        host_busy <= 1'b1;
        step(1'b1, 1'b0);
        if (host_full)
        begin
          step(1'b0, 1'b0);
          step(1'b1, 1'b0);
        end
        step(1'b1, 1'b1);
        host_busy <= 1'b0;
      end
    end
  end
endmodule : srw_host_model

/* File: testbench/srw_supervisor_test.sv */
// Testbench for the supervisor top with a host model on the bus.
// Assumes short hold and watchdog counts set by parameter.
module srw_supervisor_test;
  timeunit 1ns;
  timeprecision 1ns;
  srw_pkg::srw_supply_t supply_ok;
  logic sys_clk, rst_n, manual_reset_req_n, write_protect, scl, sda;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, q;
  logic reg_wr, reg_rd, sys_reset_out, sys_reset_oe, watchdog_fault_n;
  logic watchdog_fault_oe, aux1_undervolt_n, aux1_undervolt_oe;
  logic aux2_undervolt_n, aux2_undervolt_oe, early_supply_low_n;
  logic host_go, host_full, host_slow, host_busy;
  logic [31:0] r; // Random state
  int fail_count, total_checks, n, m;
  ////////////////////////////////////////
  srw_supervisor #(.HOLD_00(20), .HOLD_01(40), .HOLD_10(60),
    .HOLD_11(80), .WDOG_00(100), .WDOG_01(50), .WDOG_10(30))
  u_srw_supervisor
  (
    .sys_clk, .rst_n, .supply_ok, .manual_reset_req_n, .write_protect,
    .scl_in(scl), .sda_in(sda), .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .sys_reset_out, .sys_reset_oe, .watchdog_fault_n,
    .watchdog_fault_oe, .aux1_undervolt_n, .aux1_undervolt_oe,
    .aux2_undervolt_n, .aux2_undervolt_oe, .early_supply_low_n
  );
  srw_host_model u_srw_host_model
  (
    .sys_clk, .host_go, .host_full, .host_slow, .scl, .sda, .host_busy
  );
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Watchdog length in cycles for a period select, as set above
  function int wd_lim_exp(input int sel);
    return sel == 0 ? 100 : sel == 1 ? 50 : 30;
  endfunction : wd_lim_exp
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task rng(input int got, input int lo, input int hi);
    total_checks++;
    if (got < lo || got > hi)
    begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, lo);
    end
  endtask : rng
  task final_report;
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report
  // Bounded wait: 0 reset pin, 1 fault pin, 2 host busy
  task wt(input int w, input logic v, output int c);
    c = 0;
    while ((w == 0 ? sys_reset_oe : w == 1 ? watchdog_fault_oe : host_busy)
      !== v)
    begin
      @(posedge sys_clk);
      #1 c++;
      if (c > 400)
      begin
        fail_count++;
        final_report();
      end
    end
  endtask : wt
  task wr(input logic [7:0] a, input logic [7:0] dv);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= dv;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [7:0] dv);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 dv = reg_rdata;
  endtask : rd
  task bus(input logic f, input logic s);
    @(posedge sys_clk);
    host_go <= 1'b1;
    host_full <= f;
    host_slow <= s;
    @(posedge sys_clk);
    host_go <= 1'b0;
    #1 wt(2, 1'b0, n);
  endtask : bus
  // Drop main or manual for a random time, then time the release
  task hold_meas(input int e, input logic man);
    r = lfsr(r);
    @(posedge sys_clk);
    if (man)
      manual_reset_req_n <= 1'b0;
    else
      supply_ok.main_ok <= 1'b0;
    repeat (2 + r[3:0]) @(posedge sys_clk);
    #1 chk(sys_reset_oe, 1'b1);
    chk(early_supply_low_n, man);
    @(posedge sys_clk);
    manual_reset_req_n <= 1'b1;
    supply_ok.main_ok <= 1'b1;
    wt(0, 1'b0, n);
    rng(n, e, e + 3);
  endtask : hold_meas
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial
  begin
    #4000000;
    fail_count++;
    final_report();
  end
  ////////////////////////////////////////
  initial
  begin
    {rst_n, reg_wr, reg_rd, write_protect, host_go} = 5'h0;
    {manual_reset_req_n, host_full, host_slow} = 3'h7;
    {supply_ok, reg_addr, reg_wdata} = 19'h70000;
    r = 32'h6DBF;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    #1 chk({sys_reset_oe, sys_reset_out}, 2'h2);
    rd(8'h00, q);
    chk(q, 8'h61);
    rd(8'h01, q);
    chk(q, 8'h17);
    wt(0, 1'b0, n);
    rng(n, 34, 42);
    rd(8'h5A, q);
    chk(q, 8'h00);
    repeat (24)
    begin
      r = lfsr(r);
      @(posedge sys_clk);
      supply_ok.aux1_ok <= r[0];
      supply_ok.aux2_ok <= r[1];
      @(posedge sys_clk);
      #1 chk(aux1_undervolt_oe, !r[0]);
      chk({aux2_undervolt_oe, aux2_undervolt_n}, {!r[1], r[1]});
      chk(early_supply_low_n, 1'b1);
    end
    for (int h = 0; h < 4; h++)
    begin
      wr(8'h00, {h[1], 6'h30, h[0]});
      rd(8'h00, q);
      chk(q, {h[1], 6'h30, h[0]});
      hold_meas(20 * (h + 1), 1'b0);
    end
    hold_meas(80, 1'b1);
    write_protect <= 1'b1;
    wr(8'h00, 8'h00);
    rd(8'h00, q);
    chk(q, 8'hE1);
    write_protect <= 1'b0;
    for (int w = 0; w < 3; w++)
    begin
      wr(8'h00, {1'b0, w[1:0], 5'h00});
      bus(1'b1, 1'b0);
      wt(1, 1'b0, n);
      wt(1, 1'b1, m);
      m = n + m;
      rng(m, wd_lim_exp(w) - 2, wd_lim_exp(w) + 3);
    end
    bus(1'b0, 1'b0);
    repeat (4) @(posedge sys_clk);
    #1 chk({watchdog_fault_oe, watchdog_fault_n}, 2'h2);
    bus(1'b1, 1'b1);
    wt(1, 1'b0, n);
    rng(n, 0, 3);
    wr(8'h00, 8'h60);
    repeat (120) @(posedge sys_clk);
    #1 chk(watchdog_fault_oe, 1'b0);
    final_report();
  end
endmodule : srw_supervisor_test
